// ==== rx_host_model.sv ====
// host model issuing one-cycle register strobes
`timescale 1ns/100ps
module rx_host_model
(
  // clock
  input  wire logic       ref_clk_in,
  // register access
  output logic            wr_out,
  output logic            rd_out,
  output logic [7:0]      addr_out,
  output logic [7:0]      wdata_out,
  input  wire logic [7:0] rdata_in
);
  initial
  begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // idle lines show the inverse so stale values cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge ref_clk_in);
    wr_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge ref_clk_in);
    rd_out = 1'b0;
    addr_out = ~a;
    @(negedge ref_clk_in);
    d = rdata_in;
  endtask
endmodule

// ==== rx_irq_pkg.sv ====
// constants for the per-port interrupt enable block
package rx_irq_pkg;
  localparam int unsigned NUM_PORTS = 4;
  localparam int unsigned PSEL_W    = 2;
  localparam logic [7:0] ADDR_PORT_SEL   = 8'h4c;
  localparam logic [7:0] ADDR_FILTER_ST2 = 8'hd7;
  localparam logic [7:0] ADDR_IRQ_EN_HI  = 8'hd8;
  localparam logic [7:0] ADDR_IRQ_EN_LO  = 8'hd9;
  localparam logic [7:0] ADDR_IRQ_ST_HI  = 8'hda;
  localparam logic [7:0] ADDR_IRQ_ST_LO  = 8'hdb;
  localparam logic [7:0] ADDR_STS_FIRST  = 8'h4d;
  localparam logic [7:0] ADDR_STS_SECOND = 8'h4e;
  localparam logic [7:0] EN_HI_MASK      = 8'h07;
  localparam logic [7:0] EN_LO_MASK      = 8'h77;
  localparam logic [7:0] EN_RESET        = 8'h00;
  localparam logic [7:0] ZERO_BYTE       = 8'h00;
  // event bit positions inside the 16-bit {hi,lo} event vector
  localparam int unsigned EV_LOCK     = 0;
  localparam int unsigned EV_PASS     = 1;
  localparam int unsigned EV_PARITY   = 2;
  localparam int unsigned EV_OVERFLOW = 4;
  localparam int unsigned EV_LINE_CNT = 5;
  localparam int unsigned EV_LINE_LEN = 6;
  localparam int unsigned EV_CC_CRC   = 8;
  localparam int unsigned EV_CC_SEQ   = 9;
  localparam int unsigned EV_ENCODE   = 10;
  // which status register clears each event: 1 = second, 0 = first
  localparam logic [15:0] CLR_BY_SECOND = 16'h0470;
  localparam int unsigned FILT_ERR_BIT  = 6;
  localparam int unsigned FILT_DLY_W    = 6;
endpackage

// ==== rx_port_interrupt_enable.sv ====
// per-port interrupt enable hub with port select and filter status
// Behaviour
// - The filter error flag, bit 6, sets on any invalid measurement and clears on read.
// - Bits 5:0 of the filter status return the live data-delay setting, read only.
// - Each port has its own register copy, chosen by the port-select register at 0x4c.
// - High enable bit 2 lets encoding faults raise the interrupt.
// - High enable bit 1 lets control-channel sequence faults raise the interrupt.
// - High enable bit 0 lets control-channel checksum faults raise the interrupt.
// - Low enable bit 6 lets line-length changes raise the interrupt.
// - Low enable bit 5 lets line-count changes raise the interrupt.
// - Low enable bit 4 lets receive buffer overflows raise the interrupt.
// - Low enable bit 2 lets parity faults raise the interrupt.
// - Low enable bit 1 lets any port-valid change raise the interrupt.
// - Low enable bit 0 lets any lock change raise the interrupt.
// - Both enable registers reset to zero and reserved bits read zero.
// - A pending event clears when its reporting port status register is read.
`timescale 1ns/100ps
module rx_port_interrupt_enable
#(
  parameter int unsigned NUM_PORTS = rx_irq_pkg::NUM_PORTS
)
(
  // clock and reset
  input  wire logic                     ref_clk_in,
  input  wire logic                     rst_in,
  // register access from the i2c target
  input  wire logic                     reg_wr_in,
  input  wire logic                     reg_rd_in,
  input  wire logic [7:0]               reg_addr_in,
  input  wire logic [7:0]               reg_wdata_in,
  output logic      [7:0]               reg_rdata_out,
  // per-port event pulses, plus the port-valid level
  input  wire logic [NUM_PORTS-1:0]     encoding_fault_flag_in,
  input  wire logic [NUM_PORTS-1:0]     ctrl_channel_sequence_fault_in,
  input  wire logic [NUM_PORTS-1:0]     ctrl_channel_checksum_fault_in,
  input  wire logic [NUM_PORTS-1:0]     line_length_changed_flag_in,
  input  wire logic [NUM_PORTS-1:0]     line_count_changed_flag_in,
  input  wire logic [NUM_PORTS-1:0]     rx_overflow_in,
  input  wire logic [NUM_PORTS-1:0]     parity_fault_in,
  input  wire logic [NUM_PORTS-1:0]     port_valid_in,
  input  wire logic [NUM_PORTS-1:0]     lock_changed_flag_in,
  // adaptive sampling filter monitor
  input  wire logic [NUM_PORTS-1:0]     filter_bad_measure_in,
  input  wire logic [NUM_PORTS*rx_irq_pkg::FILT_DLY_W-1:0] filter_data_delay_value_in,
  // interrupt requests
  output logic      [NUM_PORTS-1:0]     port_irq_out
);
  localparam int unsigned PW = rx_irq_pkg::PSEL_W;

  // the port select field cannot reach more than four slices
  if (NUM_PORTS < 1 || NUM_PORTS > (1 << PW))
  begin : g_bad_ports
    $error("unsupported port count");
  end

  logic [PW-1:0]          port_sel_q;
  logic [NUM_PORTS-1:0]   pass_q;
  logic [7:0]             rdata_q;
  logic                   rd_sel_q;
  logic [NUM_PORTS-1:0]   irq_q;
  logic [7:0]             slice_rdata [NUM_PORTS];
  logic [NUM_PORTS-1:0]   slice_irq;

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      port_sel_q <= '0;
    else if (reg_wr_in && reg_addr_in == rx_irq_pkg::ADDR_PORT_SEL)
      port_sel_q <= reg_wdata_in[PW-1:0];
  end

  // previous port-valid level for change detection in both directions
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      pass_q <= '0;
    else
      pass_q <= port_valid_in;
  end

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++)
    begin : g_port
      rx_port_regs_if pif ();
      logic [15:0] ev;
      logic        hit;
      assign hit = (port_sel_q == PW'(p));
      assign pif.wr_en = reg_wr_in && hit;
      assign pif.rd_en = reg_rd_in && hit;
      assign pif.addr  = reg_addr_in;
      assign pif.wdata = reg_wdata_in;
      always_comb
      begin
        ev = '0;
        ev[rx_irq_pkg::EV_ENCODE]   = encoding_fault_flag_in[p];
        ev[rx_irq_pkg::EV_CC_SEQ]   = ctrl_channel_sequence_fault_in[p];
        ev[rx_irq_pkg::EV_CC_CRC]   = ctrl_channel_checksum_fault_in[p];
        ev[rx_irq_pkg::EV_LINE_LEN] = line_length_changed_flag_in[p];
        ev[rx_irq_pkg::EV_LINE_CNT] = line_count_changed_flag_in[p];
        ev[rx_irq_pkg::EV_OVERFLOW] = rx_overflow_in[p];
        ev[rx_irq_pkg::EV_PARITY]   = parity_fault_in[p];
        ev[rx_irq_pkg::EV_PASS]     = port_valid_in[p] ^ pass_q[p];
        ev[rx_irq_pkg::EV_LOCK]     = lock_changed_flag_in[p];
      end
      rx_port_irq_slice u_slice
      (
        .ref_clk_in  (ref_clk_in),
        .rst_in      (rst_in),
        .bus         (pif),
        .events_in   (ev),
        .filt_bad_in (filter_bad_measure_in[p]),
        .filt_dly_in (filter_data_delay_value_in[p*rx_irq_pkg::FILT_DLY_W +:
                                                 rx_irq_pkg::FILT_DLY_W])
      );
      assign slice_rdata[p] = pif.rdata;
      assign slice_irq[p]   = pif.irq;
    end
  endgenerate

  // slice read data lags one cycle, so remember whether the port select was read
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      rd_sel_q <= 1'b0;
    else
      rd_sel_q <= reg_rd_in && reg_addr_in == rx_irq_pkg::ADDR_PORT_SEL;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_q <= rx_irq_pkg::ZERO_BYTE;
    else if (rd_sel_q)
      rdata_q <= {{(8-PW){1'b0}}, port_sel_q};
    else
      rdata_q <= slice_rdata[port_sel_q];
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      irq_q <= '0;
    else
      irq_q <= slice_irq;
  end

  assign reg_rdata_out = rdata_q;
  assign port_irq_out  = irq_q;
endmodule

// ==== rx_port_interrupt_enable_asserts.sv ====
// port-level checker for the port interrupt enable hub
`timescale 1ns/100ps
module rx_port_interrupt_enable_asserts
#(
  parameter int unsigned NUM_PORTS = 4
)
(
  // clock and reset
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_in,
  // register access
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  input  wire logic [7:0]                 reg_addr_in,
  input  wire logic [7:0]                 reg_wdata_in,
  input  wire logic [7:0]                 reg_rdata_out,
  // filter and interrupts
  input  wire logic [NUM_PORTS*6-1:0]     filter_data_delay_value_in,
  input  wire logic [NUM_PORTS-1:0]       port_irq_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  logic [1:0] sel_q;
  logic [5:0] dly_sel;
  logic       clr;
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      sel_q <= 2'h0;
    else if (reg_wr_in && reg_addr_in == 8'h4c)
      sel_q <= reg_wdata_in[1:0];
  end
  assign dly_sel = filter_data_delay_value_in[sel_q*6 +: 6];
  // a drop is only legal after a status read or any register write
  assign clr = reg_wr_in || (reg_rd_in && (reg_addr_in == 8'h4d || reg_addr_in == 8'h4e));
  property p_hi_mask;
    reg_rd_in && reg_addr_in == 8'hd8 |-> ##2 reg_rdata_out[7:3] == 5'h00;
  endproperty
  a_hi_mask: assert property (p_hi_mask)
    else $error("enable high reserved bits set");
  property p_lo_mask;
    reg_rd_in && reg_addr_in == 8'hd9 |-> ##2 (reg_rdata_out & 8'h88) == 8'h00;
  endproperty
  a_lo_mask: assert property (p_lo_mask)
    else $error("enable low reserved bits set");
  property p_filt;
    reg_rd_in && reg_addr_in == 8'hd7 |-> ##2
      reg_rdata_out[5:0] == $past(dly_sel, 2) && !reg_rdata_out[7];
  endproperty
  a_filt: assert property (p_filt)
    else $error("filter delay readout wrong");
  property p_psel;
    reg_rd_in && reg_addr_in == 8'h4c |-> ##2 reg_rdata_out == {6'h00, $past(sel_q, 2)};
  endproperty
  a_psel: assert property (p_psel)
    else $error("port select readback wrong");
  property p_unmap;
    reg_rd_in && reg_addr_in == 8'h00 |-> ##2 reg_rdata_out == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  // clearing access, then pending or enable flop, slice flop, top flop: fall seen 3 edges later
  property p_fall;
    (|($past(port_irq_out) & ~port_irq_out)) |-> $past(clr, 3);
  endproperty
  a_fall: assert property (p_fall)
    else $error("request dropped without clearing access");
  property p_rst;
    $fell(rst_in) |-> port_irq_out == '0 && reg_rdata_out == 8'h00;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not idle after reset");
  property p_pend;
    reg_rd_in && reg_addr_in == 8'hda |-> ##2 reg_rdata_out[7:3] == 5'h00;
  endproperty
  a_pend: assert property (p_pend)
    else $error("pending high reserved bits set");
  c_irq: cover property (|port_irq_out);
  c_clr2: cover property (reg_rd_in && reg_addr_in == 8'h4e);
  c_sel: cover property (reg_wr_in && reg_addr_in == 8'h4c);
endmodule

bind rx_port_interrupt_enable rx_port_interrupt_enable_asserts #(.NUM_PORTS(NUM_PORTS)) u_chk
(
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .filter_data_delay_value_in(filter_data_delay_value_in), .port_irq_out(port_irq_out)
);

// ==== rx_port_interrupt_enable_tb.sv ====
// self-checking bench for the port interrupt enable hub
`timescale 1ns/100ps
module rx_port_interrupt_enable_tb;
  logic        clk;
  logic        rst;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  d;
  logic [3:0]  irq;
  logic [3:0]  bad;
  logic [3:0]  ev [0:10];
  logic [23:0] dly;
  logic        sec;
  int          num_errors;
  int          num_checks;
  rx_host_model host
  (
    .ref_clk_in(clk), .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata),
    .rdata_in(rdata)
  );
  rx_port_interrupt_enable dut
  (
    .ref_clk_in(clk), .rst_in(rst), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .lock_changed_flag_in(ev[0]),
    .port_valid_in(ev[1]), .parity_fault_in(ev[2]), .rx_overflow_in(ev[4]),
    .line_count_changed_flag_in(ev[5]), .line_length_changed_flag_in(ev[6]),
    .ctrl_channel_checksum_fault_in(ev[8]), .ctrl_channel_sequence_fault_in(ev[9]),
    .encoding_fault_flag_in(ev[10]), .filter_bad_measure_in(bad),
    .filter_data_delay_value_in(dly), .port_irq_out(irq)
  );
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk(n, d, e);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim;
  end
  initial
  begin
    rst = 1'b1;
    bad = 4'h0;
    dly = {6'h2c, 6'h15, 6'h3f, 6'h01};
    num_errors = 0;
    num_checks = 0;
    for (int k = 0; k < 11; k++)
      ev[k] = 4'h0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int p = 0; p < 4; p++)
    begin
      host.wr(8'h4c, 8'(p));
      rdc("en_hi", 8'hd8, 8'h00);
      rdc("en_lo", 8'hd9, 8'h00);
      host.wr(8'hd8, 8'hff);
      host.wr(8'hd9, 8'hff);
      rdc("en_hi", 8'hd8, 8'h07);
      rdc("en_lo", 8'hd9, 8'h77);
      rdc("sel", 8'h4c, 8'(p));
    end
    $display("test registers done");
    host.wr(8'h4c, 8'h02);
    for (int k = 0; k < 11; k++)
    begin
      if (k == 3 || k == 7)
        continue;
      sec = (k == 4 || k == 5 || k == 6 || k == 10);
      host.wr(8'hd8, 8'h00);
      host.wr(8'hd9, 8'h00);
      @(negedge clk);
      ev[k][2] = ~ev[k][2];
      @(negedge clk);
      // port valid is a level: one toggle is one change
      if (k != 1)
        ev[k][2] = 1'b0;
      repeat (3) @(negedge clk);
      chk("irq_off", {4'h0, irq}, 8'h00); // to
      if (k > 7)
        host.wr(8'hd8, 8'h01 << (k - 8));
      else
        host.wr(8'hd9, 8'h01 << k);
      repeat (2) @(negedge clk);
      chk("irq_on", {4'h0, irq}, 8'h04); // to
      host.rd(sec ? 8'h4d : 8'h4e, d);
      repeat (2) @(negedge clk);
      chk("irq_hold", {4'h0, irq}, 8'h04);
      host.rd(sec ? 8'h4e : 8'h4d, d);
      repeat (2) @(negedge clk);
      chk("irq_clr", {4'h0, irq}, 8'h00);
    end
    // port valid dropping back is a change too
    @(negedge clk);
    ev[1][2] = 1'b0;
    @(negedge clk);
    rdc("pend_lo", 8'hdb, 8'h02);
    rdc("pend_hi", 8'hda, 8'h00);
    host.rd(8'h4e, d);
    rdc("pend_lo", 8'hdb, 8'h02);
    host.rd(8'h4d, d);
    rdc("pend_lo", 8'hdb, 8'h00);
    $display("test events done");
    host.wr(8'h4c, 8'h03);
    @(negedge clk);
    bad[3] = 1'b1;
    @(negedge clk);
    bad[3] = 1'b0;
    rdc("filt", 8'hd7, 8'h6c);
    rdc("filt", 8'hd7, 8'h2c);
    host.wr(8'h4c, 8'h00);
    host.wr(8'hd7, 8'hff);
    rdc("filt", 8'hd7, 8'h01);
    rdc("unmap", 8'h00, 8'h00);
    rdc("pend_hi", 8'hda, 8'h00);
    rdc("pend_lo", 8'hdb, 8'h00);
    $display("test filter done");
    end_sim;
  end
endmodule

// ==== rx_port_irq_slice.sv ====
// one receive port's enable, pending and filter-status registers
`timescale 1ns/100ps
module rx_port_irq_slice
(
  input  wire logic                        ref_clk_in,
  input  wire logic                        rst_in,
  rx_port_regs_if.slice                    bus,
  input  wire logic [15:0]                 events_in,
  input  wire logic                        filt_bad_in,
  input  wire logic [rx_irq_pkg::FILT_DLY_W-1:0] filt_dly_in
);
  logic [7:0]  en_hi_q;
  logic [7:0]  en_lo_q;
  logic [15:0] pend_q;
  logic        filt_err_q;
  logic [7:0]  rdata_q;
  logic        irq_q;
  logic [15:0] clr_mask;
  logic [15:0] en_all;

  always_comb
  begin
    clr_mask = '0;
    if (bus.rd_en && bus.addr == rx_irq_pkg::ADDR_STS_SECOND)
      clr_mask = rx_irq_pkg::CLR_BY_SECOND;
    else if (bus.rd_en && bus.addr == rx_irq_pkg::ADDR_STS_FIRST)
      clr_mask = ~rx_irq_pkg::CLR_BY_SECOND;
  end

  assign en_all = {en_hi_q, en_lo_q};

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      en_hi_q <= rx_irq_pkg::EN_RESET;
      en_lo_q <= rx_irq_pkg::EN_RESET;
    end
    else if (bus.wr_en && bus.addr == rx_irq_pkg::ADDR_IRQ_EN_HI)
      en_hi_q <= bus.wdata & rx_irq_pkg::EN_HI_MASK;
    else if (bus.wr_en && bus.addr == rx_irq_pkg::ADDR_IRQ_EN_LO)
      en_lo_q <= bus.wdata & rx_irq_pkg::EN_LO_MASK;
  end

  // new event beats a clear in the same cycle
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      pend_q <= '0;
    else
      pend_q <= (pend_q & ~clr_mask) | events_in;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      filt_err_q <= 1'b0;
    else if (filt_bad_in)
      filt_err_q <= 1'b1;
    else if (bus.rd_en && bus.addr == rx_irq_pkg::ADDR_FILTER_ST2)
      filt_err_q <= 1'b0;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      irq_q <= 1'b0;
    else
      irq_q <= |(pend_q & en_all);
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_q <= rx_irq_pkg::ZERO_BYTE;
    else if (bus.rd_en)
    begin
      case (bus.addr)
        rx_irq_pkg::ADDR_FILTER_ST2: rdata_q <= {1'b0, filt_err_q, filt_dly_in};
        rx_irq_pkg::ADDR_IRQ_EN_HI:  rdata_q <= en_hi_q;
        rx_irq_pkg::ADDR_IRQ_EN_LO:  rdata_q <= en_lo_q;
        rx_irq_pkg::ADDR_IRQ_ST_HI:  rdata_q <= pend_q[15:8] & rx_irq_pkg::EN_HI_MASK;
        rx_irq_pkg::ADDR_IRQ_ST_LO:  rdata_q <= pend_q[7:0] & rx_irq_pkg::EN_LO_MASK;
        default:                     rdata_q <= rx_irq_pkg::ZERO_BYTE;
      endcase
    end
  end

  assign bus.rdata = rdata_q;
  assign bus.irq   = irq_q;
endmodule

// ==== rx_port_regs_if.sv ====
// per-port register slice carrier between top and slice module
`timescale 1ns/100ps
interface rx_port_regs_if;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       irq;
  modport top   (output wr_en, rd_en, addr, wdata, input rdata, irq);
  modport slice (input wr_en, rd_en, addr, wdata, output rdata, irq);
endinterface
